// ---- hdl/bus_muxed_gpio_ports_d_e.sv ----
// Contract
// RQ1: upper direction one makes pin input
// RQ2: upper direction zero drives pin from latch
// RQ3: upper data reads pins, writes latch
// RQ4: bus mode: upper pins carry bus 15:8
// RQ5: processor/extended modes hand pins to bus
// RQ6: other modes: upper pins are plain I/O
// RQ7: control port has four bidirectional pins
// RQ8: control direction one input, zero output
// RQ9: control data reads pins, writes latch
// RQ10: bus mode supplies latch, read, write strobes
// RQ11: read and write strobes are active low
// RQ12: strobes on control bits 0,1,2
// RQ13: fourth control pin never taken by bus
// RQ14: non-bus modes: control bits 2:0 are I/O
// RQ15: every reset sets upper direction all ones
// RQ16: software selects bank 1 before access
// RQ17: unused control register bits read zero
// RQ18: latches undefined at power-on, kept otherwise
`timescale 1ns/1ps
`default_nettype none
`include "gpio_de_regs.svh"

module bus_muxed_gpio_ports_d_e
    import gpio_de_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       warmRstReq,
    input  wire logic [1:0] cfgMode,
    input  wire logic [3:0] bankSel,
    input  wire logic [7:0] regAddr,
    input  wire logic       regWrEn,
    input  wire logic       regRdEn,
    input  wire logic [7:0] regWrData,
    output var  logic [7:0] regRdData,
    input  wire logic [7:0] busUpperOut,
    input  wire logic       busUpperOe,
    output var  logic [7:0] busUpperIn,
    input  wire logic       busAle,
    input  wire logic       busOeN,
    input  wire logic       busWrN,
    output var  logic       busModeActive,
    output var  logic       fourthCaptureInput,
    input  wire logic [7:0] upperPinIn,
    output var  logic [7:0] upperPinOut,
    output var  logic [7:0] upperPinOe,
    input  wire logic [3:0] ctrlPinIn,
    output var  logic [3:0] ctrlPinOut,
    output var  logic [3:0] ctrlPinOe
);

    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    logic [1:0] rstPipe_ff;
    logic       rstSync_n;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rstPipe_ff <= 2'b00;
        end else begin
            rstPipe_ff <= {rstPipe_ff[0], 1'b1};
        end
    end

    assign rstSync_n = rstPipe_ff[1];

    // ----------------------------------------------------------------
    // configuration strap
    // ----------------------------------------------------------------
    function automatic cfg_mode_e decodeMode(input logic [1:0] code);
        cfg_mode_e m;
        m = MODE_CONTROLLER;
        case (code)
            `GPIO_DE_CFG_PROC: m = MODE_PROCESSOR;
            `GPIO_DE_CFG_EXT:  m = MODE_EXT_CONTROLLER;
            `GPIO_DE_CFG_MCU:  m = MODE_CONTROLLER;
            `GPIO_DE_CFG_PROT: m = MODE_PROT_CONTROLLER;
            default:           m = MODE_CONTROLLER;
        endcase
        return m;
    endfunction

    cfg_mode_e mode_ff;
    logic      modeTaken_ff;
    logic      busMode;

    // strap is caught once, on the first edge after release; it is
    // a power-up setting, so later changes on the input are ignored
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            mode_ff      <= MODE_CONTROLLER;
            modeTaken_ff <= 1'b0;
        end else if (!modeTaken_ff) begin
            mode_ff      <= decodeMode(cfgMode);
            modeTaken_ff <= 1'b1;
        end
    end

    // RQ5 bus mode select
    assign busMode = modeTaken_ff &&
                     ((mode_ff == MODE_PROCESSOR) || (mode_ff == MODE_EXT_CONTROLLER));

    // ----------------------------------------------------------------
    // pin input capture
    // ----------------------------------------------------------------
    logic [7:0] upperLevel;
    logic [3:0] ctrlLevel;
    logic [11:0] allLevel;

    pin_sync3 #(
        .WIDTH (12)
    ) u_pin_sync (
        .clk       (clk),
        .rstSync_n (rstSync_n),
        .pinRaw    ({ctrlPinIn, upperPinIn}),
        .pinLevel  (allLevel)
    );

    assign upperLevel = allLevel[7:0];
    assign ctrlLevel  = allLevel[11:8];

    // ----------------------------------------------------------------
    // register decode
    // ----------------------------------------------------------------
    logic bankHit;
    logic selUpperDir;
    logic selUpperData;
    logic selCtrlDir;
    logic selCtrlData;
    logic anySel;

    // RQ16 bank one gate
    assign bankHit      = (bankSel == `GPIO_DE_BANK);
    assign selUpperDir  = bankHit && (regAddr == `GPIO_DE_OFS_UPPER_DIR);
    assign selUpperData = bankHit && (regAddr == `GPIO_DE_OFS_UPPER_DATA);
    assign selCtrlDir   = bankHit && (regAddr == `GPIO_DE_OFS_CTRL_DIR);
    assign selCtrlData  = bankHit && (regAddr == `GPIO_DE_OFS_CTRL_DATA);
    assign anySel       = selUpperDir | selUpperData | selCtrlDir | selCtrlData;

    // ----------------------------------------------------------------
    // direction registers
    // ----------------------------------------------------------------
    logic [7:0] upperDir_ff;
    logic [3:0] ctrlDir_ff;
    logic [7:0] nxt_upperDir;
    logic [3:0] nxt_ctrlDir;

    // RQ15 all resets restore inputs
    assign nxt_upperDir = warmRstReq ? `GPIO_DE_UPPER_DIR_RST :
                          (regWrEn && selUpperDir) ? regWrData : upperDir_ff;
    assign nxt_ctrlDir  = warmRstReq ? `GPIO_DE_CTRL_DIR_RST :
                          (regWrEn && selCtrlDir) ? regWrData[3:0] : ctrlDir_ff;

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            upperDir_ff <= `GPIO_DE_UPPER_DIR_RST;
            ctrlDir_ff  <= `GPIO_DE_CTRL_DIR_RST;
        end else begin
            upperDir_ff <= nxt_upperDir;
            ctrlDir_ff  <= nxt_ctrlDir;
        end
    end

    // ----------------------------------------------------------------
    // output latches
    // ----------------------------------------------------------------
    logic [7:0] upperLatch_ff;
    logic [3:0] ctrlLatch_ff;
    logic [7:0] nxt_upperLatch;
    logic [3:0] nxt_ctrlLatch;

    // RQ3 write hits latch only
    assign nxt_upperLatch = (regWrEn && selUpperData) ? regWrData : upperLatch_ff;
    // RQ9 control latch load
    assign nxt_ctrlLatch  = (regWrEn && selCtrlData) ? regWrData[3:0] : ctrlLatch_ff;

    // RQ18 latches carry no reset
    // no reset here on purpose: contents are unknown after power-up
    // and survive any warm reset; latch-fed pins stay inputs until direction is written
    always_ff @(posedge clk) begin
        upperLatch_ff <= nxt_upperLatch;
        ctrlLatch_ff  <= nxt_ctrlLatch;
    end

    // ----------------------------------------------------------------
    // pin drive selection
    // ----------------------------------------------------------------
    logic [7:0] nxt_upperOut;
    logic [7:0] nxt_upperOe;
    logic [3:0] nxt_ctrlOut;
    logic [3:0] nxt_ctrlOe;
    logic [2:0] strobeBits;

    // RQ1 direction one releases pin
    // RQ2 direction zero drives latch
    // RQ4 bus byte on upper pins
    // RQ6 plain I/O otherwise
    assign nxt_upperOut = busMode ? busUpperOut : upperLatch_ff;
    assign nxt_upperOe  = busMode ? {8{busUpperOe}} : ~upperDir_ff;

    // RQ10 bus strobes supplied
    // RQ11 active low read, write
    // RQ12 strobe bit placement
    assign strobeBits[`GPIO_DE_BIT_ALE] = busAle;
    assign strobeBits[`GPIO_DE_BIT_OE]  = busOeN;
    assign strobeBits[`GPIO_DE_BIT_WR]  = busWrN;

    // RQ7 four control pins
    // RQ8 control direction sense
    // RQ13 fourth pin stays I/O
    // RQ14 low pins plain I/O
    assign nxt_ctrlOut = busMode ? {ctrlLatch_ff[`GPIO_DE_BIT_CAP], strobeBits} : ctrlLatch_ff;
    assign nxt_ctrlOe  = busMode ? {~ctrlDir_ff[`GPIO_DE_BIT_CAP], 3'b111} : ~ctrlDir_ff;

    // every pin output is registered, so it lags its cause by one
    // edge; the oe reset of zero keeps unknown latches off the pins
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            upperPinOut <= 8'h00;
            upperPinOe  <= 8'h00;
            ctrlPinOut  <= 4'h0;
            ctrlPinOe   <= 4'h0;
        end else begin
            upperPinOut <= nxt_upperOut;
            upperPinOe  <= nxt_upperOe;
            ctrlPinOut  <= nxt_ctrlOut;
            ctrlPinOe   <= nxt_ctrlOe;
        end
    end

    // ----------------------------------------------------------------
    // bus and capture side outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            busUpperIn         <= 8'h00;
            busModeActive      <= 1'b0;
            fourthCaptureInput <= 1'b0;
        end else begin
            busUpperIn         <= upperLevel;
            busModeActive      <= busMode;
            fourthCaptureInput <= ctrlLevel[`GPIO_DE_BIT_CAP];
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    logic [7:0] rdMux;
    logic [7:0] nxt_rdData;

    // RQ3 read returns pins
    // RQ9 control read returns pins
    // RQ17 upper nibble reads zero
    assign rdMux = selUpperDir  ? upperDir_ff :
                   selUpperData ? upperLevel :
                   selCtrlDir   ? {4'h0, ctrlDir_ff} :
                   selCtrlData  ? {4'h0, ctrlLevel} : 8'h00;

    // unmapped or wrong-bank reads return zero; data holds until
    // the next read so the core may sample it late
    assign nxt_rdData = regRdEn ? (anySel ? rdMux : 8'h00) : regRdData;

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            regRdData <= 8'h00;
        end else begin
            regRdData <= nxt_rdData;
        end
    end

endmodule

`default_nettype wire

// ---- hdl/gpio_de_pkg.sv ----
package gpio_de_pkg;

    // ----------------------------------------------------------------
    // operating modes chosen by the configuration strap
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_PROCESSOR,
        MODE_EXT_CONTROLLER,
        MODE_CONTROLLER,
        MODE_PROT_CONTROLLER
    } cfg_mode_e;

    typedef logic [7:0] reg_byte_t;

endpackage

// ---- hdl/gpio_de_regs.svh ----
`ifndef GPIO_DE_REGS_SVH
`define GPIO_DE_REGS_SVH

// ----------------------------------------------------------------
// register space, bank-selected
// ----------------------------------------------------------------
`define GPIO_DE_BANK              4'h1
`define GPIO_DE_OFS_UPPER_DIR     8'h12
`define GPIO_DE_OFS_UPPER_DATA    8'h13
`define GPIO_DE_OFS_CTRL_DIR      8'h14
`define GPIO_DE_OFS_CTRL_DATA     8'h15

// ----------------------------------------------------------------
// widths and reset values
// ----------------------------------------------------------------
`define GPIO_DE_UPPER_W           8
`define GPIO_DE_CTRL_W            4
`define GPIO_DE_UPPER_DIR_RST     8'hff
`define GPIO_DE_CTRL_DIR_RST      4'hf

// ----------------------------------------------------------------
// control port bit positions in bus use
// ----------------------------------------------------------------
`define GPIO_DE_BIT_ALE           0
`define GPIO_DE_BIT_OE            1
`define GPIO_DE_BIT_WR            2
`define GPIO_DE_BIT_CAP           3

// ----------------------------------------------------------------
// configuration strap encodings
// ----------------------------------------------------------------
`define GPIO_DE_CFG_PROC          2'h0
`define GPIO_DE_CFG_EXT           2'h1
`define GPIO_DE_CFG_MCU           2'h2
`define GPIO_DE_CFG_PROT          2'h3

`endif

// ---- hdl/pin_sync3.sv ----
`timescale 1ns/1ps
`default_nettype none

module pin_sync3 #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rstSync_n,
    input  wire logic [WIDTH-1:0] pinRaw,
    output var  logic [WIDTH-1:0] pinLevel
);

    // ----------------------------------------------------------------
    // three stage capture, first stage feeds only the second
    // ----------------------------------------------------------------
    logic [WIDTH-1:0] stage1_ff;
    logic [WIDTH-1:0] stage2_ff;
    logic [WIDTH-1:0] stage3_ff;
    logic [WIDTH-1:0] level_ff;
    logic [WIDTH-1:0] nxt_level;

    // a bit only moves once two settled stages agree
    assign nxt_level = (stage2_ff & stage3_ff) | (level_ff & (stage2_ff ^ stage3_ff));

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            stage1_ff <= '0;
            stage2_ff <= '0;
            stage3_ff <= '0;
            level_ff  <= '0;
        end else begin
            stage1_ff <= pinRaw;
            stage2_ff <= stage1_ff;
            stage3_ff <= stage2_ff;
            level_ff  <= nxt_level;
        end
    end

    assign pinLevel = level_ff;

endmodule

`default_nettype wire

// ---- testbench/gpio_de_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module gpio_de_chk (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       warmRstReq,
    input wire logic [3:0] bankSel,
    input wire logic [7:0] regAddr,
    input wire logic       regWrEn,
    input wire logic       regRdEn,
    input wire logic [7:0] regWrData,
    input wire logic [7:0] regRdData,
    input wire logic [7:0] busUpperOut,
    input wire logic       busUpperOe,
    input wire logic       busAle,
    input wire logic       busOeN,
    input wire logic       busWrN,
    input wire logic       busModeActive,
    input wire logic [7:0] upperPinOut,
    input wire logic [7:0] upperPinOe,
    input wire logic [3:0] ctrlPinOut,
    input wire logic [3:0] ctrlPinOe
);
    // ----------------
    // pin relations
    // ----------------
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire logic bk = bankSel == 4'h1;
    wire logic io = !busModeActive;
    // bus mode seen on this edge and the one before it
    logic      busPrev_ff;
    always_ff @(posedge clk) begin
        busPrev_ff <= busModeActive;
    end
    wire logic bus2 = busModeActive && busPrev_ff;
    // a warm reset in the same cycle wins over a direction write
    sequence upDir; io && regWrEn && bk && regAddr == 8'h12 && !warmRstReq; endsequence
    sequence upDat; io && regWrEn && bk && regAddr == 8'h13; endsequence
    sequence ctDir; regWrEn && bk && regAddr == 8'h14 && !warmRstReq; endsequence
    sequence ctDat; regWrEn && bk && regAddr == 8'h15; endsequence
    up_dir_a: assert property (upDir |-> ##2 upperPinOe == ~$past(regWrData, 2))
        else $error("upper oe does not follow direction");
    up_dat_a: assert property (upDat |-> ##2 upperPinOut == $past(regWrData, 2))
        else $error("upper out does not follow latch");
    ct_pin3_a: assert property (ctDir |-> ##2 ctrlPinOe[3] == !$past(regWrData[3], 2))
        else $error("ctrl pin 3 direction wrong");
    ct_low_a: assert property (ctDir ##0 io |-> ##2 ctrlPinOe[2:0] == ~$past(regWrData[2:0], 2))
        else $error("ctrl low pins direction wrong");
    ct_dat_a: assert property (ctDat |-> ##2 ctrlPinOut[3] == $past(regWrData[3], 2))
        else $error("ctrl pin 3 latch wrong");
    bus_upper_a: assert property (bus2 |-> upperPinOut == $past(busUpperOut) && upperPinOe == {8{$past(busUpperOe)}})
        else $error("upper pins do not carry bus");
    strobe_map_a: assert property (bus2 |-> ctrlPinOe[2:0] == 3'h7 && ctrlPinOut[2:0] == {$past(busWrN), $past(busOeN), $past(busAle)})
        else $error("bus strobes misplaced");
    warm_dir_a: assert property (warmRstReq && io |-> ##2 upperPinOe == 8'h00 && !ctrlPinOe[3])
        else $error("warm reset left outputs");
    rd_refuse_a: assert property (regRdEn && !(bk && regAddr inside {[8'h12:8'h15]}) |=> regRdData == 8'h00)
        else $error("refused read not zero");
    rd_nibble_a: assert property (regRdEn && bk && regAddr[7:1] == 7'h0a |=> regRdData[7:4] == 4'h0)
        else $error("ctrl upper bits not zero");
    mode_keep_a: assert property (busModeActive |=> busModeActive)
        else $error("bus mode dropped");
endmodule
`default_nettype wire

// ---- testbench/gpio_pin_world.sv ----
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_world (
    input  wire logic [7:0] upOut,
    input  wire logic [7:0] upOe,
    input  wire logic [7:0] upExt,
    input  wire logic [3:0] ctOut,
    input  wire logic [3:0] ctOe,
    input  wire logic [3:0] ctExt,
    output var  logic [7:0] upPin,
    output var  logic [3:0] ctPin,
    output var  logic       memRead,
    output var  logic       memWrite
);
    // ----------------
    // board side
    // ----------------
    // released pins follow peripheral
    assign upPin = (upOe & upOut) | (~upOe & upExt);
    assign ctPin = (ctOe & ctOut) | (~ctOe & ctExt);
    assign memRead = !ctPin[1];
    assign memWrite = !ctPin[2];
endmodule
`default_nettype wire

// ---- testbench/test_bus_muxed_gpio_ports_d_e.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_bus_muxed_gpio_ports_d_e;
    logic       clk, rst_n, warmRstReq, regWrEn, regRdEn, busUpperOe, busAle, busOeN, busWrN;
    logic       busModeActive, fourthCaptureInput, memRead, memWrite;
    logic [1:0] cfgMode;
    logic [3:0] bankSel, ctrlPinIn, ctrlPinOut, ctrlPinOe, ctExt;
    logic [7:0] regAddr, regWrData, regRdData, busUpperOut, busUpperIn, upExt;
    logic [7:0] upperPinIn, upperPinOut, upperPinOe;
    int         miscompares = 0;
    int         cmp_count = 0;

    bus_muxed_gpio_ports_d_e i_dut (
        .clk                (clk),
        .rst_n              (rst_n),
        .warmRstReq         (warmRstReq),
        .cfgMode            (cfgMode),
        .bankSel            (bankSel),
        .regAddr            (regAddr),
        .regWrEn            (regWrEn),
        .regRdEn            (regRdEn),
        .regWrData          (regWrData),
        .regRdData          (regRdData),
        .busUpperOut        (busUpperOut),
        .busUpperOe         (busUpperOe),
        .busUpperIn         (busUpperIn),
        .busAle             (busAle),
        .busOeN             (busOeN),
        .busWrN             (busWrN),
        .busModeActive      (busModeActive),
        .fourthCaptureInput (fourthCaptureInput),
        .upperPinIn         (upperPinIn),
        .upperPinOut        (upperPinOut),
        .upperPinOe         (upperPinOe),
        .ctrlPinIn          (ctrlPinIn),
        .ctrlPinOut         (ctrlPinOut),
        .ctrlPinOe          (ctrlPinOe)
    );
    gpio_pin_world i_world (
        .upOut   (upperPinOut),
        .upOe    (upperPinOe),
        .upExt   (upExt),
        .ctOut   (ctrlPinOut),
        .ctOe    (ctrlPinOe),
        .ctExt   (ctExt),
        .upPin   (upperPinIn),
        .ctPin   (ctrlPinIn),
        .memRead (memRead),
        .memWrite(memWrite)
    );

    // ----------------
    // helpers
    // ----------------
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(negedge clk);
        regWrEn = 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string nm);
        @(negedge clk);
        regAddr = a;
        regRdEn = 1'b1;
        @(negedge clk);
        regRdEn = 1'b0;
        chk(nm, regRdData, exp);
    endtask
    task automatic restart(input logic [1:0] m);
        cfgMode = m;
        rst_n = 1'b0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        repeat (6) @(negedge clk);
    endtask
    task automatic report_and_stop;
        if (miscompares == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ----------------
    // scenarios
    // ----------------
    task automatic io_walk;
        rdc(8'h12, 8'hff, "upper dir");
        rdc(8'h14, 8'h0f, "ctrl dir");
        wr(8'h13, 8'h5a);
        wr(8'h12, 8'h00);
        repeat (8) @(negedge clk);
        chk("upper oe", upperPinOe, 8'hff);
        chk("upper out", upperPinOut, 8'h5a);
        rdc(8'h13, 8'h5a, "upper pins");
        wr(8'h12, 8'hf0);
        repeat (8) @(negedge clk);
        rdc(8'h13, 8'hca, "upper mixed");
        chk("bus in", busUpperIn, 8'hca);
        wr(8'h15, 8'hf5);
        wr(8'h14, 8'hfa);
        repeat (8) @(negedge clk);
        chk("ctrl oe", {4'h0, ctrlPinOe}, 8'h05);
        rdc(8'h14, 8'h0a, "ctrl dir bits");
        rdc(8'h15, 8'h07, "ctrl pins");
    endtask
    task automatic refused;
        bankSel = 4'h2;
        wr(8'h13, 8'hff);
        rdc(8'h13, 8'h00, "bank 2 read");
        bankSel = 4'h1;
        rdc(8'h20, 8'h00, "unmapped");
        repeat (2) @(negedge clk);
        chk("latch kept", upperPinOut, 8'h5a);
    endtask
    task automatic warm;
        warmRstReq = 1'b1;
        @(negedge clk);
        warmRstReq = 1'b0;
        ctExt = 4'he;
        repeat (8) @(negedge clk);
        rdc(8'h12, 8'hff, "warm dir");
        chk("warm latch", upperPinOut, 8'h5a);
        chk("capture", {7'h0, fourthCaptureInput}, 8'h01);
    endtask
    task automatic bus_modes;
        for (int m = 0; m < 4; m++) begin
            restart(m[1:0]);
            chk("mode", {7'h0, busModeActive}, {7'h0, m < 2});
            if (m < 2) begin
                chk("bus out", upperPinOut, 8'h96);
                chk("bus oe", upperPinOe, 8'hff);
                chk("strobes", {ctrlPinOe, 1'b0, ctrlPinOut[2:0]}, 8'h75);
                chk("strobe sense", {6'h0, memRead, memWrite}, 8'h02);
            end else begin
                chk("gpio oe", upperPinOe | {4'h0, ctrlPinOe}, 8'h00);
            end
            wr(8'h15, 8'h08);
            wr(8'h14, 8'h07);
            repeat (3) @(negedge clk);
            chk("pin 3", {6'h0, ctrlPinOe[3], ctrlPinOut[3]}, 8'h03);
        end
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        warmRstReq = 1'b0;
        bankSel = 4'h1;
        regAddr = 8'h00;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        regWrData = 8'h00;
        busUpperOut = 8'h96;
        busUpperOe = 1'b1;
        busAle = 1'b1;
        busOeN = 1'b0;
        busWrN = 1'b1;
        upExt = 8'hc3;
        ctExt = 4'h6;
        restart(2'h2);
        io_walk;
        refused;
        warm;
        bus_modes;
        report_and_stop;
    end
    // whole run is well under 1000 cycles
    initial begin
        #20000;
        miscompares++;
        report_and_stop;
    end
endmodule
bind bus_muxed_gpio_ports_d_e gpio_de_chk i_chk (.*);
`default_nettype wire
